// file: rtl/ssrsr_defs.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from rtl/ files
`ifndef SSRSR_DEFS_SVH
`define SSRSR_DEFS_SVH
`define SSRSR_IDX_CH5 8'h2c
`define SSRSR_IDX_CH6 8'h2d
`define SSRSR_IDX_CH7 8'h2e
`define SSRSR_IDX_CTRL 8'h30
`define SSRSR_IDX_STAT 8'h31
`define SSRSR_RST_CH5 8'h04
`define SSRSR_RST_CH6 8'h05
`define SSRSR_RST_CH7 8'h06
`define SSRSR_ROUTE_HI 6
`define SSRSR_ROUTE_LO 5
`define SSRSR_SLOT_HI 4
`define SSRSR_SLOT_LO 0
`define SSRSR_RSVD_BIT 7
`define SSRSR_CLK_NS 20
`define SSRSR_BCLK_MIN_NS 160
`define SSRSR_BCLK_MIN_CYC ((`SSRSR_BCLK_MIN_NS + `SSRSR_CLK_NS - 1) / `SSRSR_CLK_NS)
`endif

// file: rtl/ssrsr_pkg.sv
// types for the secondary serial port receive slot router
// assumes the defs header for numeric constants
package ssrsr_pkg;
    typedef enum logic [1:0] {
        SSRSR_ROUTE_OFF,
        SSRSR_ROUTE_PLAY,
        SSRSR_ROUTE_LOOP,
        SSRSR_ROUTE_CHAIN
    } ssrsr_route_t;
    typedef enum logic {
        SSRSR_FMT_TDM,
        SSRSR_FMT_LR
    } ssrsr_fmt_t;
    typedef enum logic [1:0] {
        SSRSR_DST_PLAY,
        SSRSR_DST_LOOP,
        SSRSR_DST_CHAIN
    } ssrsr_dst_t;
endpackage : ssrsr_pkg

// file: rtl/ssrsr_fifo.sv
// synchronous fifo of flip-flops, valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module ssrsr_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;
    always_comb begin
        push = in_valid_in && (cnt_reg != AW'(0) + (AW+1)'(DEPTH));
        pop = (cnt_reg != '0) && out_ready_in;
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
        if (push) begin
            mem_reg[wr_reg] <= in_data_in;
        end
    end
    assign in_ready_out = cnt_reg != (AW+1)'(DEPTH);
    assign out_valid_out = cnt_reg != '0;
    assign out_data_out = mem_reg[rd_reg];
endmodule : ssrsr_fifo
`default_nettype wire

// file: rtl/ssrsr_router.sv
// receive channels 5-7 of the secondary serial port: config regs and slot router
// assumes classic wishbone master on ref_clk_in; link pins asynchronous
// Function
// - route zero disables channel, no data
// - route one carries same-numbered playback data
// - ch5: two loops record 1, three reserved
// - ch6: two loops record 2, three chains 1
// - ch7: two loops record 3, three chains 2
// - slot field: tdm direct, left/right halves
// - reset slots 4,5,6, routes disabled
// - bit seven reads zero, not writable
//
// Design decision made here: the Wishbone register port.
`include "ssrsr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ssrsr_router #(
    parameter int WORD_BITS = 32,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic link_bclk_in,
    input wire logic link_fsync_in,
    input wire logic link_din_in,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    output logic [WORD_BITS-1:0] rx_data_out,
    output logic [1:0] rx_chan_out,
    output var ssrsr_pkg::ssrsr_dst_t rx_dst_out,
    output logic [1:0] rx_dst_idx_out
);
    import ssrsr_pkg::*;
    localparam int FW = WORD_BITS + 6;
    localparam int BW = $clog2(WORD_BITS);

    // word index = byte address / 4
    function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
        hit = (a[7:2] == idx[5:0]);
    endfunction : hit

    logic [7:0] cfg_reg [3], cfg_next [3];
    ssrsr_fmt_t fmt_reg, fmt_next;
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic [7:0] drop_reg, drop_next;
    logic wb_req;
    assign wb_req = wb_cyc_in && wb_stb_in && !ack_reg;

    // register file
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            cfg_next[i] = cfg_reg[i];
        end
        fmt_next = fmt_reg;
        ack_next = wb_req;
        rdat_next = rdat_reg;
        if (wb_req && wb_we_in && wb_sel_in[0]) begin
            if (hit(wb_adr_in, `SSRSR_IDX_CH5)) begin
                cfg_next[0] = {1'b0, wb_dat_in[6:0]};
            end else if (hit(wb_adr_in, `SSRSR_IDX_CH6)) begin
                cfg_next[1] = {1'b0, wb_dat_in[6:0]};
            end else if (hit(wb_adr_in, `SSRSR_IDX_CH7)) begin
                cfg_next[2] = {1'b0, wb_dat_in[6:0]};
            end else if (hit(wb_adr_in, `SSRSR_IDX_CTRL)) begin
                fmt_next = ssrsr_fmt_t'(wb_dat_in[0]);
            end
        end
        if (wb_req && !wb_we_in) begin
            if (hit(wb_adr_in, `SSRSR_IDX_CH5)) begin
                rdat_next = {24'h000000, cfg_reg[0]};
            end else if (hit(wb_adr_in, `SSRSR_IDX_CH6)) begin
                rdat_next = {24'h000000, cfg_reg[1]};
            end else if (hit(wb_adr_in, `SSRSR_IDX_CH7)) begin
                rdat_next = {24'h000000, cfg_reg[2]};
            end else if (hit(wb_adr_in, `SSRSR_IDX_CTRL)) begin
                rdat_next = {31'h00000000, fmt_reg};
            end else if (hit(wb_adr_in, `SSRSR_IDX_STAT)) begin
                rdat_next = {24'h000000, drop_reg};
            end else begin
                rdat_next = 32'h00000000; // unmapped reads zero
            end
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            cfg_reg[0] <= `SSRSR_RST_CH5;
            cfg_reg[1] <= `SSRSR_RST_CH6;
            cfg_reg[2] <= `SSRSR_RST_CH7;
            fmt_reg <= SSRSR_FMT_TDM;
            ack_reg <= 1'b0;
            rdat_reg <= 32'h00000000;
        end else begin
            for (int i = 0; i < 3; i++) begin
                cfg_reg[i] <= cfg_next[i];
            end
            fmt_reg <= fmt_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end
    assign wb_ack_out = ack_reg;
    assign wb_dat_out = rdat_reg;

    // link synchronisers; first stage read only by second
    logic [1:0] bclk_s_reg, fs_s_reg, din_s_reg;
    logic bclk_d_reg, fs_d_reg;
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            bclk_s_reg <= 2'b00;
            fs_s_reg <= 2'b00;
            din_s_reg <= 2'b00;
            bclk_d_reg <= 1'b0;
            fs_d_reg <= 1'b0;
        end else begin
            bclk_s_reg <= {bclk_s_reg[0], link_bclk_in};
            fs_s_reg <= {fs_s_reg[0], link_fsync_in};
            din_s_reg <= {din_s_reg[0], link_din_in};
            bclk_d_reg <= bclk_s_reg[1];
            fs_d_reg <= fs_s_reg[1];
        end
    end
    logic bclk_rise;
    assign bclk_rise = bclk_s_reg[1] && !bclk_d_reg;

    // deserialiser: tdm counts slots from fsync rise; lr format
    // splits at fsync level (low left, high right)
    logic [4:0] slot_reg, slot_next;
    logic [BW-1:0] bit_reg, bit_next;
    logic [WORD_BITS-1:0] sh_reg, sh_next;
    logic fs_prev_reg, fs_prev_next;
    logic wvalid_reg, wvalid_next;
    logic [4:0] wslot_reg, wslot_next;
    logic [WORD_BITS-1:0] wdata_reg, wdata_next;
    always_comb begin
        slot_next = slot_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        fs_prev_next = fs_prev_reg;
        wvalid_next = 1'b0;
        wslot_next = wslot_reg;
        wdata_next = wdata_reg;
        if (bclk_rise) begin
            fs_prev_next = fs_d_reg;
            sh_next = {sh_reg[WORD_BITS-2:0], din_s_reg[1]};
            if (fs_d_reg != fs_prev_reg && (fmt_reg == SSRSR_FMT_LR || fs_d_reg)) begin
                bit_next = BW'(1);
                sh_next = {{(WORD_BITS-1){1'b0}}, din_s_reg[1]};
                if (fmt_reg == SSRSR_FMT_LR) begin
                    slot_next = {fs_d_reg, 4'h0};
                end else begin
                    slot_next = 5'h00;
                end
            end else if (bit_reg == BW'(WORD_BITS-1)) begin
                bit_next = '0;
                wvalid_next = 1'b1;
                wslot_next = slot_reg;
                wdata_next = {sh_reg[WORD_BITS-2:0], din_s_reg[1]};
                slot_next = slot_reg + 1'b1;
            end else begin
                bit_next = bit_reg + 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            slot_reg <= 5'h00;
            bit_reg <= '0;
            sh_reg <= '0;
            fs_prev_reg <= 1'b0;
            wvalid_reg <= 1'b0;
            wslot_reg <= 5'h00;
            wdata_reg <= '0;
        end else begin
            slot_reg <= slot_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            fs_prev_reg <= fs_prev_next;
            wvalid_reg <= wvalid_next;
            wslot_reg <= wslot_next;
            wdata_reg <= wdata_next;
        end
    end

    // slot match and route; lowest channel wins a shared slot
    logic hit_any;
    logic [1:0] hit_ch;
    ssrsr_route_t hit_route;
    logic f_ready;
    logic [FW-1:0] f_in;
    logic [1:0] dst_code;
    always_comb begin
        hit_any = 1'b0;
        hit_ch = 2'd0;
        hit_route = SSRSR_ROUTE_OFF;
        for (int i = 2; i >= 0; i--) begin
            if (cfg_reg[i][`SSRSR_SLOT_HI:`SSRSR_SLOT_LO] == wslot_reg &&
                    cfg_reg[i][`SSRSR_ROUTE_HI:`SSRSR_ROUTE_LO] != 2'b00 &&
                    !(i == 0 && cfg_reg[i][`SSRSR_ROUTE_HI:`SSRSR_ROUTE_LO] == 2'b11)) begin
                hit_any = 1'b1;
                hit_ch = 2'(i);
                hit_route = ssrsr_route_t'(cfg_reg[i][`SSRSR_ROUTE_HI:`SSRSR_ROUTE_LO]);
            end
        end
        case (hit_route)
            SSRSR_ROUTE_LOOP: dst_code = SSRSR_DST_LOOP;
            SSRSR_ROUTE_CHAIN: dst_code = SSRSR_DST_CHAIN;
            default: dst_code = SSRSR_DST_PLAY;
        endcase
        f_in = {hit_ch, dst_code, 2'b00, wdata_reg};
    end
    // destination index: play ch 5..7, loop record 1..3, chain device 1..2
    logic [1:0] o_ch, o_dst;
    logic o_valid;
    logic [WORD_BITS-1:0] o_data;
    logic [1:0] o_pad;
    ssrsr_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .in_valid_in(wvalid_reg && hit_any),
        .in_ready_out(f_ready),
        .in_data_in(f_in),
        .out_valid_out(o_valid),
        .out_ready_in(!rx_valid_out || rx_ready_in),
        .out_data_out({o_ch, o_dst, o_pad, o_data})
    );

    // output stage straight from flops; drops counted when fifo full
    logic ov_reg, ov_next;
    logic [WORD_BITS-1:0] od_reg, od_next;
    logic [1:0] oc_reg, oc_next, odst_reg, odst_next, oi_reg, oi_next;
    always_comb begin
        ov_next = ov_reg;
        od_next = od_reg;
        oc_next = oc_reg;
        odst_next = odst_reg;
        oi_next = oi_reg;
        drop_next = drop_reg;
        if (!ov_reg || rx_ready_in) begin
            ov_next = o_valid;
            od_next = o_data;
            oc_next = o_ch;
            odst_next = o_dst;
            oi_next = (o_dst == SSRSR_DST_CHAIN) ? o_ch - 2'd1 : o_ch;
        end
        if (wvalid_reg && hit_any && !f_ready && drop_reg != 8'hff) begin
            drop_next = drop_reg + 8'h01;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ov_reg <= 1'b0;
            od_reg <= '0;
            oc_reg <= 2'd0;
            odst_reg <= 2'd0;
            oi_reg <= 2'd0;
            drop_reg <= 8'h00;
        end else begin
            ov_reg <= ov_next;
            od_reg <= od_next;
            oc_reg <= oc_next;
            odst_reg <= odst_next;
            oi_reg <= oi_next;
            drop_reg <= drop_next;
        end
    end
    assign rx_valid_out = ov_reg;
    assign rx_data_out = od_reg;
    assign rx_chan_out = oc_reg;
    assign rx_dst_out = ssrsr_dst_t'(odst_reg);
    assign rx_dst_idx_out = oi_reg;

    property p_rst_vals;
        @(posedge ref_clk_in) $fell(sys_rst_in) |->
            cfg_reg[0] == 8'h04 && cfg_reg[1] == 8'h05 && cfg_reg[2] == 8'h06;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
    property p_bit7;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
            !cfg_reg[0][7] && !cfg_reg[1][7] && !cfg_reg[2][7];
    endproperty
    a_bit7: assert property (p_bit7) else $error("bit 7 set");
    property p_off;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
            hit_any |-> cfg_reg[hit_ch][6:5] != 2'b00;
    endproperty
    a_off: assert property (p_off) else $error("disabled channel routed");
    property p_rsvd5;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
            wvalid_reg && cfg_reg[0][6:5] == 2'b11 && cfg_reg[0][4:0] == wslot_reg |->
                !(hit_any && hit_ch == 2'd0);
    endproperty
    a_rsvd5: assert property (p_rsvd5) else $error("ch5 reserved route used");
    property p_play;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
            rx_valid_out && rx_dst_out == SSRSR_DST_PLAY |-> rx_dst_idx_out == rx_chan_out;
    endproperty
    a_play: assert property (p_play) else $error("playback route wrong");
    property p_chain;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
            rx_valid_out && rx_dst_out == SSRSR_DST_CHAIN |->
                rx_chan_out != 2'd0 && rx_dst_idx_out == rx_chan_out - 2'd1;
    endproperty
    a_chain: assert property (p_chain) else $error("chain route wrong");
    property p_loop;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
            rx_valid_out && rx_dst_out == SSRSR_DST_LOOP |-> rx_dst_idx_out == rx_chan_out;
    endproperty
    a_loop: assert property (p_loop) else $error("loop route wrong");
    property p_slot;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
            bclk_rise && fmt_reg == SSRSR_FMT_LR && fs_d_reg != fs_prev_reg |=>
                slot_reg == {$past(fs_d_reg), 4'h0};
    endproperty
    a_slot: assert property (p_slot) else $error("slot mismatch");
    sequence s_word;
        wvalid_reg && hit_any && f_ready;
    endsequence
    property p_deliver;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
            s_word |=> o_valid;
    endproperty
    a_deliver: assert property (p_deliver) else $error("word not queued");
endmodule : ssrsr_router
`default_nettype wire

// file: verif/ssrsr_link_host.sv
// behavioural far-side audio host: bit clock, frame sync and serial data
// assumes the router samples data msb first on the bit clock rise
`timescale 1ns/1ps
`default_nettype none
module ssrsr_link_host #(
    parameter int HALF_NS = 80
) (
    output logic link_bclk_out,
    output logic link_fsync_out,
    output logic link_din_out
);
    initial begin
        link_bclk_out = 1'b0;
        link_fsync_out = 1'b0;
        link_din_out = 1'b0;
    end
    // per-slot pattern, three of the four bytes differ per slot so misrouted slots show
    function automatic logic [31:0] slot_word(input int s);
        logic [7:0] b;
        b = 8'(s);
        return {b ^ 8'h3c, ~b, 8'h5a, b};
    endfunction : slot_word
    task automatic put_bit(input logic d, input logic fs);
        link_din_out <= d;
        link_fsync_out <= fs;
        #(HALF_NS) link_bclk_out <= 1'b1;
        #(HALF_NS) link_bclk_out <= 1'b0;
    endtask : put_bit
    task automatic put_word(input int s, input logic fs, input logic first);
        logic [31:0] w;
        w = slot_word(s);
        for (int i = 31; i >= 0; i--) begin
            put_bit(w[i], fs | (first && i == 31));
        end
    endtask : put_word
    // lr: one lone high bit gives a fresh falling edge to open the left half
    task automatic send_frame(input logic lr, input int nl, input int nr);
        if (lr) begin
            put_bit(1'b0, 1'b1);
        end
        for (int k = 0; k < nl; k++) begin
            put_word(k, 1'b0, !lr && k == 0);
        end
        for (int k = 0; k < nr; k++) begin
            put_word(16 + k, 1'b1, 1'b0);
        end
        // released data line: clock stops, data shows the inverse
        link_din_out <= ~link_din_out;
        // idle gap so the next frame does not rewrite data in the same step
        #(HALF_NS);
    endtask : send_frame
endmodule : ssrsr_link_host
`default_nettype wire

// file: verif/secondary_serial_rx_slot_router_bench.sv
// self-checking bench: wishbone register tasks, link frames, fifo stall
// assumes the link host model and the router's registered one-word outputs
`timescale 1ns/1ps
`default_nettype none
module secondary_serial_rx_slot_router_bench;
    import ssrsr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic bclk, fsync, din;
    logic rx_valid, rx_ready = 1'b1;
    logic [31:0] rx_data;
    logic [1:0] rx_chan, rx_idx;
    ssrsr_dst_t rx_dst;
    logic [37:0] got[$];
    int n_fail = 0;
    int num_checks = 0;
    always #10 clk = ~clk;
    ssrsr_router #(.WORD_BITS(32), .FIFO_DEPTH(16)) u_ssrsr_router (
        .ref_clk_in(clk), .sys_rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .link_bclk_in(bclk),
        .link_fsync_in(fsync), .link_din_in(din), .rx_valid_out(rx_valid),
        .rx_ready_in(rx_ready), .rx_data_out(rx_data), .rx_chan_out(rx_chan),
        .rx_dst_out(rx_dst), .rx_dst_idx_out(rx_idx));
    ssrsr_link_host u_ssrsr_link_host (
        .link_bclk_out(bclk), .link_fsync_out(fsync), .link_din_out(din));
    always @(posedge clk) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            got.push_back({rx_chan, rx_dst, rx_idx, rx_data});
        end
    end
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // classic cycle: hold everything until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = (ack === 1'b1) ? rdat : 32'hx;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, {24'h0, d}, r);
        if (r === 32'hx) chk(0, 1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask : rd
    function automatic logic [37:0] ex(input int ch, input int rt, input int s);
        logic [1:0] idx;
        idx = (rt == 3) ? 2'(ch - 1) : 2'(ch);
        return {2'(ch), 2'(rt - 1), idx, u_ssrsr_link_host.slot_word(s)};
    endfunction : ex
    task automatic take(input int ch, input int rt, input int s);
        logic [37:0] w;
        w = (got.size() > 0) ? got.pop_front() : 38'hx;
        chk(w, ex(ch, rt, s));
    endtask : take
    // one frame, then bounded wait for words plus a quiet spell for strays
    task automatic frame(input logic lr, input int nl, input int nr, input int nw);
        int n;
        u_ssrsr_link_host.send_frame(lr, nl, nr);
        n = 0;
        while (got.size() < nw && n < 300) begin
            @(posedge clk);
            n++;
        end
        repeat (40) @(posedge clk);
        chk(got.size(), nw);
    endtask : frame
    initial begin
        #800000;
        n_fail++;
        wrap_up();
    end
    initial begin
        logic [31:0] r;
        int s;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(8'hb0, 32'h04);
        rd(8'hb4, 32'h05);
        rd(8'hb8, 32'h06);
        wr(8'hb0, 8'h7f);
        rd(8'hb0, 32'h7f);
        rd(8'hfc, 32'h00);
        wr(8'hb0, 8'h24);
        wr(8'hb4, 8'h41);
        wr(8'hb8, 8'h7f);
        frame(1'b0, 32, 0, 3);
        take(1, 2, 1);
        take(0, 1, 4);
        take(2, 3, 31);
        wr(8'hb0, 8'h60);
        wr(8'hb4, 8'h62);
        wr(8'hb8, 8'h43);
        frame(1'b0, 4, 0, 2);
        take(1, 3, 2);
        take(2, 2, 3);
        wr(8'hb0, 8'h40);
        wr(8'hb4, 8'h01);
        wr(8'hb8, 8'h23);
        frame(1'b0, 4, 0, 2);
        take(0, 2, 0);
        take(2, 1, 3);
        // fill: sink stalled over six frames, 18 words for 16 fifo places plus the output stage
        wr(8'hb0, 8'h20);
        wr(8'hb4, 8'h21);
        wr(8'hb8, 8'h22);
        rx_ready <= 1'b0;
        repeat (6) u_ssrsr_link_host.send_frame(1'b0, 3, 0);
        repeat (40) @(posedge clk);
        bus(1'b0, 8'hc4, 32'h0, r);
        s = int'(r[7:0]);
        chk(s > 0, 1);
        repeat (80) @(posedge clk) rx_ready <= ~rx_ready;
        rx_ready <= 1'b1;
        repeat (20) @(posedge clk);
        chk(got.size() + s, 18);
        for (int i = 0; got.size() > 0; i++) begin
            take(i % 3, 1, i % 3);
        end
        // left/right format: 16 names right slot 0
        wr(8'hc0, 8'h01);
        wr(8'hb0, 8'h30);
        wr(8'hb4, 8'h21);
        wr(8'hb8, 8'h00);
        frame(1'b1, 2, 1, 2);
        take(1, 1, 1);
        take(0, 1, 16);
        wrap_up();
    end
endmodule : secondary_serial_rx_slot_router_bench
`default_nettype wire
